// ===== rtl/gpio_pkg.sv
package gpio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 5;
  localparam int unsigned DATA_WIDTH = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] FIRST_DIR_OFFSET   = 5'h00;
  localparam logic [ADDR_WIDTH-1:0] FIRST_DATA_OFFSET  = 5'h04;
  localparam logic [ADDR_WIDTH-1:0] FIRST_PULL_OFFSET  = 5'h08;
  localparam logic [ADDR_WIDTH-1:0] SECOND_DIR_OFFSET  = 5'h0C;
  localparam logic [ADDR_WIDTH-1:0] SECOND_DATA_OFFSET = 5'h10;
  localparam logic [ADDR_WIDTH-1:0] SECOND_PULL_OFFSET = 5'h14;

  // ----------------------------------------------------------------
  // Reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  PULL_RESET     = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE = 8'hFF;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ----------------------------------------------------------------
  // Pin group of one port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] oe_n;
    logic [7:0] pull_en;
  } pin_drive_s;

endpackage : gpio_pkg

// ===== rtl/dual_byte_gpio_ports.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dual_byte_gpio_ports
  import gpio_pkg::*;
#(
  parameter int unsigned WIDTH = gpio_pkg::PORT_WIDTH
) (
  // Clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                rstn,
  // AXI4-Lite write address
  input  wire logic [gpio_pkg::ADDR_WIDTH-1:0]     s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [gpio_pkg::DATA_WIDTH-1:0]     s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [gpio_pkg::ADDR_WIDTH-1:0]     s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  // AXI4-Lite read data
  output logic [gpio_pkg::DATA_WIDTH-1:0]          s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // First port pins
  input  wire logic [WIDTH-1:0]                    first_port_pin_in,
  output gpio_pkg::pin_drive_s                     first_port_pin,
  // Second port pins
  input  wire logic [WIDTH-1:0]                    second_port_pin_in,
  output gpio_pkg::pin_drive_s                     second_port_pin
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] first_port_direction_reg;
  logic [WIDTH-1:0] first_port_output_data_reg;
  logic [WIDTH-1:0] first_port_pullup_enable_reg;
  logic [WIDTH-1:0] second_port_direction_reg;
  logic [WIDTH-1:0] second_port_output_data_reg;
  logic [WIDTH-1:0] second_port_pullup_enable_reg;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] first_meta_reg;
  logic [WIDTH-1:0] first_sync_reg;
  logic [WIDTH-1:0] first_stage_reg;
  logic [WIDTH-1:0] first_level_reg;
  logic [WIDTH-1:0] second_meta_reg;
  logic [WIDTH-1:0] second_sync_reg;
  logic [WIDTH-1:0] second_stage_reg;
  logic [WIDTH-1:0] second_level_reg;

  // Three stages; a level is accepted only when stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_meta_reg   <= '0;
      first_sync_reg   <= '0;
      first_stage_reg  <= '0;
      second_meta_reg  <= '0;
      second_sync_reg  <= '0;
      second_stage_reg <= '0;
    end else begin
      first_meta_reg   <= first_port_pin_in;
      first_sync_reg   <= first_meta_reg;
      first_stage_reg  <= first_sync_reg;
      second_meta_reg  <= second_port_pin_in;
      second_sync_reg  <= second_meta_reg;
      second_stage_reg <= second_sync_reg;
    end
  end

  // Per-bit agreement filter keeps a glitch from reaching a read
  wire [WIDTH-1:0] first_agree  = ~(first_sync_reg ^ first_stage_reg);
  wire [WIDTH-1:0] second_agree = ~(second_sync_reg ^ second_stage_reg);
  wire [WIDTH-1:0] first_level_next  = (first_agree & first_stage_reg)
                                     | (~first_agree & first_level_reg);
  wire [WIDTH-1:0] second_level_next = (second_agree & second_stage_reg)
                                     | (~second_agree & second_level_reg);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_level_reg  <= '0;
      second_level_reg <= '0;
    end else begin
      first_level_reg  <= first_level_next;
      second_level_reg <= second_level_next;
    end
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Output bits read the latch, input bits read the pin
  function automatic logic [WIDTH-1:0] port_read(input logic [WIDTH-1:0] dir,
                                                 input logic [WIDTH-1:0] latch,
                                                 input logic [WIDTH-1:0] pins);
    port_read = (dir & latch) | (~dir & pins);
  endfunction : port_read

  // Byte-lane merge; only lane 0 carries register bits
  function automatic logic [WIDTH-1:0] lane_merge(input logic [WIDTH-1:0] old_val,
                                                  input logic [31:0]      wdata,
                                                  input logic [3:0]       strb);
    lane_merge = strb[0] ? wdata[WIDTH-1:0] : old_val;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] aw_addr_reg;
  logic                  aw_held_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  w_held_reg;

  // Address and data may arrive in either order; each is held until both exist
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_first_dir   = do_write && aw_addr_reg == FIRST_DIR_OFFSET;
  wire wr_first_data  = do_write && aw_addr_reg == FIRST_DATA_OFFSET;
  wire wr_first_pull  = do_write && aw_addr_reg == FIRST_PULL_OFFSET;
  wire wr_second_dir  = do_write && aw_addr_reg == SECOND_DIR_OFFSET;
  wire wr_second_data = do_write && aw_addr_reg == SECOND_DATA_OFFSET;
  wire wr_second_pull = do_write && aw_addr_reg == SECOND_PULL_OFFSET;
  wire wr_mapped      = wr_first_dir | wr_first_data | wr_first_pull
                      | wr_second_dir | wr_second_data | wr_second_pull;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_addr_reg   <= '0;
      aw_held_reg   <= 1'b0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_reg & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates; directions and data all reset to input, low, no pull-up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_port_direction_reg      <= DIR_RESET;
      first_port_output_data_reg    <= DATA_RESET;
      first_port_pullup_enable_reg  <= PULL_RESET;
      second_port_direction_reg     <= DIR_RESET;
      second_port_output_data_reg   <= DATA_RESET;
      second_port_pullup_enable_reg <= PULL_RESET;
    end else begin
      if (wr_first_dir)
        first_port_direction_reg <= lane_merge(first_port_direction_reg,
                                               w_data_reg, w_strb_reg);
      if (wr_first_data)
        first_port_output_data_reg <= lane_merge(first_port_output_data_reg,
                                                 w_data_reg, w_strb_reg);
      if (wr_first_pull)
        first_port_pullup_enable_reg <= lane_merge(first_port_pullup_enable_reg,
                                                   w_data_reg, w_strb_reg);
      if (wr_second_dir)
        second_port_direction_reg <= lane_merge(second_port_direction_reg,
                                                w_data_reg, w_strb_reg);
      if (wr_second_data)
        second_port_output_data_reg <= lane_merge(second_port_output_data_reg,
                                                  w_data_reg, w_strb_reg);
      if (wr_second_pull)
        second_port_pullup_enable_reg <= lane_merge(second_port_pullup_enable_reg,
                                                    w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] first_read  = port_read(first_port_direction_reg,
                                           first_port_output_data_reg,
                                           first_level_reg);
  wire [WIDTH-1:0] second_read = port_read(second_port_direction_reg,
                                           second_port_output_data_reg,
                                           second_level_reg);
  wire             ar_take     = s_axi_arvalid & s_axi_arready;
  logic [WIDTH-1:0] rd_byte;
  logic             rd_mapped;

  // Address decode; write-only directions answer a constant
  always_comb begin
    rd_mapped = 1'b1;
    if (s_axi_araddr == FIRST_DIR_OFFSET) begin
      rd_byte = DIR_READ_VALUE;
    end else if (s_axi_araddr == FIRST_DATA_OFFSET) begin
      rd_byte = first_read;
    end else if (s_axi_araddr == FIRST_PULL_OFFSET) begin
      rd_byte = first_port_pullup_enable_reg;
    end else if (s_axi_araddr == SECOND_DIR_OFFSET) begin
      rd_byte = DIR_READ_VALUE;
    end else if (s_axi_araddr == SECOND_DATA_OFFSET) begin
      rd_byte = second_read;
    end else if (s_axi_araddr == SECOND_PULL_OFFSET) begin
      rd_byte = second_port_pullup_enable_reg;
    end else begin
      rd_byte   = '0;
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {{(DATA_WIDTH-WIDTH){1'b0}}, rd_byte};
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pull-up only on an input pin with its enable set; reset clears both
  wire [WIDTH-1:0] first_pull_on  = ~first_port_direction_reg
                                  & first_port_pullup_enable_reg;
  wire [WIDTH-1:0] second_pull_on = ~second_port_direction_reg
                                  & second_port_pullup_enable_reg;

  // Registered so every pin output comes from a flop; one cycle behind registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_port_pin  <= '{out_val: DATA_RESET, oe_n: 8'hFF, pull_en: PULL_RESET};
      second_port_pin <= '{out_val: DATA_RESET, oe_n: 8'hFF, pull_en: PULL_RESET};
    end else begin
      first_port_pin.out_val  <= first_port_output_data_reg;
      first_port_pin.oe_n     <= ~first_port_direction_reg;
      first_port_pin.pull_en  <= first_pull_on;
      second_port_pin.out_val <= second_port_output_data_reg;
      second_port_pin.oe_n    <= ~second_port_direction_reg;
      second_port_pin.pull_en <= second_pull_on;
    end
  end

endmodule : dual_byte_gpio_ports

`default_nettype wire

// ===== dv/gpio_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_asserts #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // Bus handshakes
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [4:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  // Pin groups
  input wire gpio_pkg::pin_drive_s first_port_pin,
  input wire gpio_pkg::pin_drive_s second_port_pin
);
  import gpio_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------
  first_pull_a : assert property ((first_port_pin.pull_en & ~first_port_pin.oe_n) == 8'h00)
    else $error("first port pull-up on a driven pin");
  second_pull_a : assert property ((second_port_pin.pull_en & ~second_port_pin.oe_n) == 8'h00)
    else $error("second port pull-up on a driven pin");
  // Reset leaves every pin an undriven input, pull-ups off
  reset_pins_a : assert property ($rose(rstn) |-> first_port_pin.oe_n == 8'hFF &&
    second_port_pin.oe_n == 8'hFF && (first_port_pin.pull_en | second_port_pin.pull_en) == 8'h00)
    else $error("pins not idle after reset");
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  write_resp_a : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_resp_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  // Direction reads give the fixed answer only
  dir_read_a : assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr == FIRST_DIR_OFFSET || s_axi_araddr == SECOND_DIR_OFFSET)
    |=> s_axi_rdata[7:0] == DIR_READ_VALUE && s_axi_rresp == RESP_OKAY)
    else $error("direction read value wrong");
  upper_zero_a : assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  unmapped_a : assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > SECOND_PULL_OFFSET |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : gpio_asserts
bind dual_byte_gpio_ports gpio_asserts #(.WIDTH(WIDTH)) gpio_asserts_i (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .first_port_pin(first_port_pin),
  .second_port_pin(second_port_pin));
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpio_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic       awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_a = 8'h00, pin_b = 8'h00;
  logic [3:0] wstrb = 4'hF;
  pin_drive_s drv_a, drv_b;
  int         fails = 0, check_count = 0, cycles = 0;

  dual_byte_gpio_ports dual_byte_gpio_ports_i (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_port_pin_in(pin_a), .first_port_pin(drv_a),
    .second_port_pin_in(pin_b), .second_port_pin(drv_b));

  // 25 MHz clock; hang guard at 5000 cycles, well above the fewer than two hundred cycles used
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axi_read

  task automatic expect_read(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(what, exp, d);
    check("read resp", 32'(RESP_OKAY), 32'(r));
  endtask : expect_read

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_state;
    check("first oe_n", 32'h0000_00FF, 32'(drv_a.oe_n));
    check("second oe_n", 32'h0000_00FF, 32'(drv_b.oe_n));
    check("first pull", 32'h0000_0000, 32'(drv_a.pull_en));
    check("second pull", 32'h0000_0000, 32'(drv_b.pull_en));
    expect_read(FIRST_PULL_OFFSET, 32'h0000_0000, "first pull reg");
    expect_read(SECOND_PULL_OFFSET, 32'h0000_0000, "second pull reg");
  endtask : reset_state

  // Mixed directions: outputs read back stored bits, inputs the pins
  task automatic port_mix(input bit p);
    logic [4:0] base;
    logic [1:0] r;
    base = p ? SECOND_DIR_OFFSET : FIRST_DIR_OFFSET;
    axi_write(base, 8'hA5, r);
    check("dir bresp", 32'(RESP_OKAY), 32'(r));
    axi_write(base + 5'h04, 8'h3C, r);
    check("data bresp", 32'(RESP_OKAY), 32'(r));
    axi_write(base + 5'h08, 8'hF0, r);
    check("pull bresp", 32'(RESP_OKAY), 32'(r));
    if (p) pin_b <= 8'h96;
    else pin_a <= 8'h96;
    expect_read(base, 32'h0000_00FF, "dir read");
    repeat (6) @(posedge clk_sys);
    #1;
    check("oe_n", 32'h0000_005A, 32'(p ? drv_b.oe_n : drv_a.oe_n));
    check("driven", 32'h0000_0024, 32'((p ? drv_b.out_val : drv_a.out_val) & 8'hA5));
    check("pull_en", 32'h0000_0050, 32'(p ? drv_b.pull_en : drv_a.pull_en));
    expect_read(base + 5'h04, 32'h0000_0036, "mixed read");
    if (p) pin_b <= 8'h69;
    else pin_a <= 8'h69;
    repeat (6) @(posedge clk_sys);
    expect_read(base + 5'h04, 32'h0000_006C, "pin change read");
    // All outputs: pull-ups must drop although the enable bits stay set
    axi_write(base, 8'hFF, r);
    repeat (2) @(posedge clk_sys);
    #1;
    check("all out pull", 32'h0000_0000, 32'(p ? drv_b.pull_en : drv_a.pull_en));
    expect_read(base + 5'h04, 32'h0000_003C, "output read");
  endtask : port_mix

  // Unmapped places are refused and touch nothing
  task automatic unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(5'h18, 8'h77, r);
    check("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    axi_read(5'h1C, d, r);
    check("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    // Lane 0 strobe low: the write is accepted but must leave the byte alone
    wstrb <= 4'hE;
    axi_write(FIRST_PULL_OFFSET, 8'h0F, r);
    wstrb <= 4'hF;
    check("masked bresp", 32'(RESP_OKAY), 32'(r));
    expect_read(FIRST_PULL_OFFSET, 32'h0000_00F0, "pull kept");
  endtask : unmapped

  // Reset in mid-run: enabled pull-ups must drop at once, registers clear
  task automatic reset_again;
    logic [1:0] r;
    axi_write(FIRST_DIR_OFFSET, 8'h00, r);
    check("first dir bresp", 32'(RESP_OKAY), 32'(r));
    axi_write(SECOND_DIR_OFFSET, 8'h00, r);
    check("second dir bresp", 32'(RESP_OKAY), 32'(r));
    @(posedge clk_sys);
    #1;
    check("first pull on", 32'h0000_00F0, 32'(drv_a.pull_en));
    check("second pull on", 32'h0000_00F0, 32'(drv_b.pull_en));
    @(posedge clk_sys);
    rstn <= 1'b0;
    #1;
    check("first pull in reset", 32'h0000_0000, 32'(drv_a.pull_en));
    check("second pull in reset", 32'h0000_0000, 32'(drv_b.pull_en));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("first oe_n again", 32'h0000_00FF, 32'(drv_a.oe_n));
    check("second oe_n again", 32'h0000_00FF, 32'(drv_b.oe_n));
    check("first out again", 32'h0000_0000, 32'(drv_a.out_val));
    expect_read(FIRST_PULL_OFFSET, 32'h0000_0000, "first pull cleared");
    expect_read(SECOND_PULL_OFFSET, 32'h0000_0000, "second pull cleared");
  endtask : reset_again

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_state();
    port_mix(1'b0);
    port_mix(1'b1);
    unmapped();
    reset_again();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
